// [adcf_regs.vh]
// What this block does
// - result readable once done flag rises
// - single-ended code is unsigned vin*1024/vref
// - 0x000 is ground, 0x3FF is vref minus step
// - differential code is diff*gain*512/vref
// - differential two's complement, saturates 0x200..0x1FF
// - bit 9 in high byte is sign
// - same pin selectable as both inputs
// - left_adjust picks left or right alignment
// - input select at 0x07, data 0x27, reset 0x00
// - io offsets to 0x3F; data address adds 0x20
// - extended space from 0x60 data access only
// - fields: ref 7:6, adjust 5, channel 4:0
// - reference decode 00 pin, 01 supply, 11 internal
// - ref/channel changes wait for conversion end
// - left_adjust change reformats result immediately
// - channel codes: 0-7 single, 30 bandgap, 31 ground
`ifndef ADCF_REGS_VH
`define ADCF_REGS_VH

// io-space offsets (io instructions reach 0x00..0x3F)
`define ADCF_IO_INPUT_SELECT 6'h07
`define ADCF_IO_RESULT_LOW 6'h04
`define ADCF_IO_RESULT_HIGH 6'h05

// data-space mapping of the io space
`define ADCF_DS_IO_BASE 16'h0020
`define ADCF_DS_EXT_BASE 16'h0060

// reset value of the input select register
`define ADCF_INPUT_SELECT_RESET 8'h00

// field positions of the input select register
`define ADCF_REF_HI 7
`define ADCF_REF_LO 6
`define ADCF_ADJ_BIT 5
`define ADCF_CHAN_HI 4
`define ADCF_CHAN_LO 0

// reference select encodings
`define ADCF_REF_PIN 2'h0
`define ADCF_REF_SUPPLY 2'h1
`define ADCF_REF_RESERVED 2'h2
`define ADCF_REF_INTERNAL 2'h3

// channel codes with a special meaning
`define ADCF_CHAN_SE_LAST 5'h07
`define ADCF_CHAN_BANDGAP 5'h1E
`define ADCF_CHAN_GROUND 5'h1F

// gain encodings on gain_select
`define ADCF_GAIN_1X 2'h0
`define ADCF_GAIN_10X 2'h1
`define ADCF_GAIN_200X 2'h2

// result code limits
`define ADCF_SE_ZERO 10'h000
`define ADCF_SE_MAX 10'h3FF
`define ADCF_DIFF_MAX 10'h1FF
`define ADCF_DIFF_MIN 10'h200

`endif

// [adcf_align.v]
`timescale 1ns/10ps
`default_nettype none
`include "adcf_regs.vh"

// places the 10-bit code into the two result bytes
module adcf_align (
    input wire [9:0] code, // stored conversion code
    input wire left_adjust, // live alignment bit
    output wire [7:0] low_byte, // result low byte image
    output wire [7:0] high_byte // result high byte image
);

    // purely combinational so a new alignment shows at once
    assign low_byte = left_adjust ? {code[1:0], 6'h00} : code[7:0];
    assign high_byte = left_adjust ? code[9:2] : {6'h00, code[9:8]};

endmodule
`default_nettype wire

// [adcf_chan_dec.v]
`timescale 1ns/10ps
`default_nettype none
`include "adcf_regs.vh"

// turns the 5-bit channel code into input routing and gain
module adcf_chan_dec (
    input wire [4:0] chan, // channel/gain code
    output reg diff_mode, // differential pair chosen
    output reg [2:0] se_channel, // single-ended pin
    output reg [2:0] pos_channel, // positive pin
    output reg [2:0] neg_channel, // negative pin
    output reg [1:0] gain_select, // gain code
    output reg bandgap_sel, // bandgap routed in
    output reg ground_sel, // ground routed in
    output reg chan_reserved // code never used
);

    // table decode; pos may equal neg for offset capture
    always @* begin
        diff_mode = 1'b0;
        se_channel = 3'h0;
        pos_channel = 3'h0;
        neg_channel = 3'h0;
        gain_select = `ADCF_GAIN_1X;
        bandgap_sel = 1'b0;
        ground_sel = 1'b0;
        chan_reserved = 1'b0;
        if (chan <= `ADCF_CHAN_SE_LAST) begin
            se_channel = chan[2:0];
        end else if (chan == `ADCF_CHAN_BANDGAP) begin
            bandgap_sel = 1'b1;
        end else if (chan == `ADCF_CHAN_GROUND) begin
            ground_sel = 1'b1;
        end else if (chan[4:3] == 2'h1) begin
            // gain pairs on pins 0/1 over 0 and 2/3 over 2
            diff_mode = 1'b1;
            pos_channel = {1'b0, chan[2], chan[0]};
            neg_channel = {1'b0, chan[2], 1'b0};
            gain_select = chan[1] ? `ADCF_GAIN_200X : `ADCF_GAIN_10X;
        end else begin
            // 1x pairs: pins 0-7 over pin 1, pins 0-5 over pin 2
            diff_mode = 1'b1;
            pos_channel = chan[2:0];
            neg_channel = chan[3] ? 3'h2 : 3'h1;
            gain_select = `ADCF_GAIN_1X;
        end
    end

endmodule
`default_nettype wire

// [adcf_top.v]
`timescale 1ns/10ps
`default_nettype none
`include "adcf_regs.vh"

// result coding, alignment and input selection of the converter
// the core delivers an already scaled signed quotient, so no
// divider lives here: this block clips, stores and presents it
// io and load/store accesses reach the same three registers;
// result bytes are read only, writes to them are dropped
// limitation: the bytes are read independently, so a result
// landing between the two reads mixes two conversions
module adcf_top #(
    parameter RAW_W = 12 // width of the scaled signed core code
) (
    input wire core_clk, // system clock
    input wire rstn, // async reset, active low
    input wire [5:0] io_addr, // io instruction address
    input wire io_wr, // io write strobe
    input wire io_rd, // io read strobe
    input wire [15:0] ds_addr, // load/store address
    input wire ds_wr, // load/store write strobe
    input wire ds_rd, // load/store read strobe
    input wire [7:0] wdata, // write data
    output reg [7:0] rdata, // read data, held
    output wire reg_hit, // address claimed this cycle
    input wire conv_busy, // conversion in progress
    input wire conv_done, // conversion finished, one cycle
    input wire [RAW_W-1:0] conv_raw, // signed scaled code
    input wire done_flag_clear, // clear of the done flag
    output reg conversion_done_flag, // sticky done flag
    output reg result_sign_bit, // bit 9 of the code
    output reg [1:0] active_ref_select, // ref in use
    output reg ref_internal_on, // internal ref enabled
    output reg ref_avcc_on, // supply used as ref
    output reg ref_reserved, // reserved ref code held
    output wire diff_mode, // differential pair in use
    output wire [2:0] se_channel, // single-ended pin
    output wire [2:0] pos_channel, // positive pin
    output wire [2:0] neg_channel, // negative pin
    output wire [1:0] gain_select, // gain in use
    output wire bandgap_sel, // bandgap in use
    output wire ground_sel, // ground in use
    output wire chan_reserved // reserved channel in use
);

    // register select codes returned by the decoder
    localparam [1:0] SEL_NONE = 2'h0;
    localparam [1:0] SEL_INPUT = 2'h1;
    localparam [1:0] SEL_LOW = 2'h2;
    localparam [1:0] SEL_HIGH = 2'h3;
    // the none code doubles as the miss code: a miss reads back
    // zero and leaves reg_hit low for another block to answer

    // maps an io offset to one of our registers
    function [1:0] reg_of;
        input [5:0] off;
        begin
            if (off == `ADCF_IO_INPUT_SELECT) begin
                // selection byte, read and write
                reg_of = SEL_INPUT;
            end else if (off == `ADCF_IO_RESULT_LOW) begin
                // lower result byte, read only
                reg_of = SEL_LOW;
            end else if (off == `ADCF_IO_RESULT_HIGH) begin
                // upper result byte, read only
                reg_of = SEL_HIGH;
            end else begin
                // an offset owned by some other block
                reg_of = SEL_NONE;
            end
        end
    endfunction

    // stored state
    reg [7:0] adc_input_select; // software-visible selection
    reg [4:0] active_chan; // channel locked for the core
    reg [9:0] result_code; // last finished code
    // nets of the bus decode
    wire [15:0] ds_off_full; // data address minus io base
    wire ds_in_io; // data address inside io window
    wire [1:0] io_sel; // register hit by io access
    wire [1:0] ds_sel; // register hit by data access
    wire io_act; // io access this cycle
    wire ds_act; // data access this cycle
    wire [1:0] acc_sel; // register of the winning access
    wire acc_wr; // winning access writes
    wire acc_rd; // winning access reads
    // nets of the result path
    wire [7:0] low_img; // aligned low byte
    wire [7:0] high_img; // aligned high byte
    wire raw_neg; // core code below zero
    wire raw_hi_se; // core code above 10-bit unsigned
    wire raw_fits_diff; // core code fits 10-bit signed
    reg [9:0] next_code; // coded value for this result
    wire sel_follow; // active selection may track

    // address decode
    // two views of one space: io offsets 0x00..0x3F, and the
    // same registers 0x20 higher through load/store

    // data space sees io offsets shifted up by the io base
    assign ds_off_full = ds_addr - `ADCF_DS_IO_BASE;

    // extended space from 0x60 is never reached via io offsets
    assign ds_in_io = (ds_addr >= `ADCF_DS_IO_BASE) && (ds_addr < `ADCF_DS_EXT_BASE);

    // io instructions carry six bits, so only 0x00..0x3F
    assign io_sel = reg_of(io_addr);
    assign ds_sel = ds_in_io ? reg_of(ds_off_full[5:0]) : SEL_NONE;

    assign io_act = io_wr | io_rd;
    assign ds_act = ds_wr | ds_rd;

    // io access wins if both arrive together; core issues one
    // the priority only keeps the decode defined should a
    // faulty master ever raise both strobes at once
    assign acc_sel = io_act ? io_sel : (ds_act ? ds_sel : SEL_NONE);
    assign acc_wr = io_act ? io_wr : ds_wr;
    assign acc_rd = io_act ? io_rd : ds_rd;

    // tells the core the address belongs to this block
    assign reg_hit = (io_act | ds_act) && (acc_sel != SEL_NONE);

    // input select register
    // the byte is stored as written, reserved codes included;
    // the lock stage decides what reaches the analog side

    // all three fields read/write, cleared by reset
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            adc_input_select <= `ADCF_INPUT_SELECT_RESET;
        end else if (acc_wr && acc_sel == SEL_INPUT) begin
            adc_input_select <= wdata;
        end
    end

    // selection lock
    // a change in mid conversion would disturb the sample, so
    // the analog side sees the register only while idle or on the completing cycle

    // tracks the register except while a conversion samples;
    // updating resumes on the completing cycle
    assign sel_follow = !conv_busy || conv_done;

    // reference and channel are shadowed, left_adjust is not
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            // external pin, internal reference off, input 0
            active_ref_select <= `ADCF_REF_PIN;
            active_chan <= 5'h00;
        end else if (sel_follow) begin
            active_ref_select <= adc_input_select[`ADCF_REF_HI:`ADCF_REF_LO];
            active_chan <= adc_input_select[`ADCF_CHAN_HI:`ADCF_CHAN_LO];
        end
    end

    // reference decode from the locked selection
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ref_internal_on <= 1'b0;
            ref_avcc_on <= 1'b0;
            ref_reserved <= 1'b0;
        end else if (sel_follow) begin
            // reserved code keeps internal ref off, safest with a pin
            // source present
            case (adc_input_select[`ADCF_REF_HI:`ADCF_REF_LO])
                `ADCF_REF_PIN: begin
                    // pin drives the reference, nothing on chip
                    ref_internal_on <= 1'b0;
                    ref_avcc_on <= 1'b0;
                    ref_reserved <= 1'b0;
                end
                `ADCF_REF_SUPPLY: begin
                    // analog supply switched onto the reference
                    ref_internal_on <= 1'b0;
                    ref_avcc_on <= 1'b1;
                    ref_reserved <= 1'b0;
                end
                `ADCF_REF_INTERNAL: begin
                    // on-chip 2.56V source enabled
                    ref_internal_on <= 1'b1;
                    ref_avcc_on <= 1'b0;
                    ref_reserved <= 1'b0;
                end
                default: begin
                    // reserved code: all off, flagged for software
                    ref_internal_on <= 1'b0;
                    ref_avcc_on <= 1'b0;
                    ref_reserved <= 1'b1;
                end
            endcase
        end
    end

    // channel decode of the locked code
    // combinational on the locked code, so routing only moves
    // when the lock lets the code move
    adcf_chan_dec u_chan_dec (
        .chan(active_chan),
        .diff_mode(diff_mode),
        .se_channel(se_channel),
        .pos_channel(pos_channel),
        .neg_channel(neg_channel),
        .gain_select(gain_select),
        .bandgap_sel(bandgap_sel),
        .ground_sel(ground_sel),
        .chan_reserved(chan_reserved)
    );

    // result coding
    // the stored code is always 10 bits; anything wider from
    // the core folds onto the nearest legal code

    // range checks done on bits, no signed arithmetic needed
    // a raw width below 12 would leave no bit above the
    // unsigned range, so the parameter must stay at 12 or more
    assign raw_neg = conv_raw[RAW_W-1];
    assign raw_hi_se = !raw_neg && (|conv_raw[RAW_W-2:10]);
    assign raw_fits_diff = (&conv_raw[RAW_W-1:9]) || !(|conv_raw[RAW_W-1:9]);

    // core delivers the scaled quotient; here it is clipped
    always @* begin
        next_code = conv_raw[9:0];
        if (diff_mode) begin
            // two's complement, clipped to -512..+511
            if (!raw_fits_diff) begin
                next_code = raw_neg ? `ADCF_DIFF_MIN : `ADCF_DIFF_MAX;
            end
        end else if (ground_sel) begin
            // grounded input reads zero whatever the core says
            next_code = `ADCF_SE_ZERO;
        end else if (raw_neg) begin
            // below ground has no unsigned code, so zero
            next_code = `ADCF_SE_ZERO;
        end else if (raw_hi_se) begin
            // above the reference reads full scale
            next_code = `ADCF_SE_MAX;
        end
    end

    // code captured on the same edge the done flag rises
    // sign kept in its own flop for a quick polarity check
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            result_code <= 10'h000;
            result_sign_bit <= 1'b0;
        end else if (conv_done) begin
            result_code <= next_code;
            result_sign_bit <= next_code[9];
        end
    end

    // done flag: a completion in the clear cycle still sets it
    // otherwise it stays up until the clear arrives
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            conversion_done_flag <= 1'b0;
        end else if (conv_done) begin
            conversion_done_flag <= 1'b1;
        end else if (done_flag_clear) begin
            conversion_done_flag <= 1'b0;
        end
    end

    // alignment follows the live bit, not the locked copy
    // so software may flip alignment and reread the same
    // result without starting a new conversion
    adcf_align u_align (
        .code(result_code),
        .left_adjust(adc_input_select[`ADCF_ADJ_BIT]),
        .low_byte(low_img),
        .high_byte(high_img)
    );

    // read port
    // one registered read path for both access kinds, so the
    // data lands on the cycle after the strobe either way

    // data held until the next read; unmapped reads give zero
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else if (acc_rd) begin
            case (acc_sel)
                SEL_INPUT: begin
                    // selection byte exactly as stored
                    rdata <= adc_input_select;
                end
                SEL_LOW: begin
                    // low byte in the live alignment
                    rdata <= low_img;
                end
                SEL_HIGH: begin
                    // high byte, sign at bit 1 or bit 7
                    rdata <= high_img;
                end
                default: begin
                    // unmapped offset reads zero
                    rdata <= 8'h00;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// [adcf_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
// port-level watch on the converter's coding and selection logic
module adcf_monitor #(
    parameter RAW_W = 12 // raw code width
) (
    input wire logic core_clk, // clock
    input wire logic rstn, // reset, low
    input wire logic [5:0] io_addr, // io address
    input wire logic io_wr, // io write
    input wire logic io_rd, // io read
    input wire logic [15:0] ds_addr, // data address
    input wire logic ds_wr, // data write
    input wire logic ds_rd, // data read
    input wire logic [7:0] wdata, // write data
    input wire logic [7:0] rdata, // read data
    input wire logic reg_hit, // claimed
    input wire logic conv_busy, // converting
    input wire logic conv_done, // finish pulse
    input wire logic [RAW_W-1:0] conv_raw, // raw code
    input wire logic conversion_done_flag, // done flag
    input wire logic result_sign_bit, // code bit 9
    input wire logic [1:0] active_ref_select, // locked ref
    input wire logic ref_internal_on, // internal ref
    input wire logic ref_avcc_on, // supply ref
    input wire logic ref_reserved, // reserved ref
    input wire logic diff_mode, // pair in use
    input wire logic [2:0] pos_channel, // positive pin
    input wire logic [2:0] neg_channel // negative pin
);
    // single domain, so clock and reset are given once
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    flag_set_a: assert property (conv_done |=> conversion_done_flag)
        else $error("done flag missing after conversion");
    neg_sign_a: assert property (conv_done && diff_mode && conv_raw[RAW_W-1]
        |=> result_sign_bit)
        else $error("negative result without sign");
    pos_sign_a: assert property (conv_done && diff_mode && !conv_raw[RAW_W-1]
        |=> !result_sign_bit)
        else $error("positive result with sign");
    ref_lock_a: assert property (conv_busy && !conv_done |=> $stable(active_ref_select))
        else $error("reference moved mid conversion");
    chan_lock_a: assert property (conv_busy && !conv_done
        |=> $stable({diff_mode, pos_channel, neg_channel}))
        else $error("channel moved mid conversion");
    ref_decode_a: assert property (ref_internal_on == (active_ref_select == 2'h3)
        && ref_avcc_on == (active_ref_select == 2'h1)
        && ref_reserved == (active_ref_select == 2'h2))
        else $error("reference decode wrong");
    ref_track_a: assert property (io_wr && io_addr == 6'h07 ##1 !conv_busy
        |=> {active_ref_select, 6'h00} == ($past(wdata, 2) & 8'hC0))
        else $error("idle reference not tracking");
    read_back_a: assert property (io_wr && io_addr == 6'h07
        ##1 io_rd && !io_wr && io_addr == 6'h07 |=> rdata == $past(wdata, 2))
        else $error("select read back wrong");
    io_hit_a: assert property ((io_rd || io_wr) && io_addr == 6'h07 |-> reg_hit)
        else $error("io select access missed");
    data_hit_a: assert property (!io_rd && !io_wr && (ds_rd || ds_wr)
        && ds_addr == 16'h0027 |-> reg_hit)
        else $error("data select access missed");
    ext_miss_a: assert property (!io_rd && !io_wr && ds_addr >= 16'h0060 |-> !reg_hit)
        else $error("extended space claimed");
endmodule

bind adcf_top adcf_monitor #(.RAW_W(RAW_W)) u_adcf_monitor (.core_clk, .rstn, .io_addr, .io_wr,
    .io_rd, .ds_addr, .ds_wr, .ds_rd, .wdata, .rdata, .reg_hit, .conv_busy, .conv_done,
    .conv_raw, .conversion_done_flag, .result_sign_bit, .active_ref_select, .ref_internal_on,
    .ref_avcc_on, .ref_reserved, .diff_mode, .pos_channel, .neg_channel);
`default_nettype wire

// [adcf_conv_model.sv]
`timescale 1ns/10ps
`default_nettype none
// stands in for the analog conversion core
module adcf_conv_model #(
    parameter RAW_W = 12 // raw code width
) (
    input wire logic core_clk, // clock
    output logic conv_busy, // converting
    output logic conv_done, // finish pulse
    output logic [RAW_W-1:0] conv_raw // code, valid with pulse
);
    // idle core
    initial begin
        conv_busy = 1'b0;
        conv_done = 1'b0;
        conv_raw = {RAW_W{1'b0}};
    end
    // busy for n cycles, then the code with a one-cycle pulse
    task automatic convert(input logic [RAW_W-1:0] raw, input int n);
        @(negedge core_clk);
        conv_busy = 1'b1;
        repeat (n) @(negedge core_clk);
        conv_done = 1'b1;
        conv_raw = raw;
        @(negedge core_clk);
        conv_busy = 1'b0;
        conv_done = 1'b0;
        // code only valid with the pulse, so show junk after it
        conv_raw = ~raw;
    endtask
endmodule
`default_nettype wire

// [tb.sv]
`timescale 1ns/10ps
`default_nettype none
// bus-level checks of coding, alignment and input selection
module tb;
    localparam logic [3:0] IW = 4'h1, IR = 4'h2, DW = 4'h4, DR = 4'h8; // access kinds
    logic core_clk, rstn, io_wr, io_rd, ds_wr, ds_rd, done_flag_clear; // bench drives
    logic [5:0] io_addr; // io address
    logic [15:0] ds_addr; // data address
    logic [7:0] wdata, rdata; // bus data
    logic reg_hit, conv_busy, conv_done, conversion_done_flag, result_sign_bit; // status
    logic [11:0] conv_raw; // raw code
    logic [1:0] active_ref_select, gain_select; // selection
    logic ref_internal_on, ref_avcc_on, ref_reserved, diff_mode; // decodes
    logic bandgap_sel, ground_sel, chan_reserved; // decodes
    logic [2:0] se_channel, pos_channel, neg_channel; // routing
    int bad_count, checks_done, cycles; // tallies
    wire [8:0] df_view = {diff_mode, pos_channel, neg_channel, gain_select}; // pair view
    wire [2:0] ref_view = {ref_internal_on, ref_avcc_on, ref_reserved}; // ref decode view

    adcf_top #(.RAW_W(12)) u_adcf_top (.core_clk, .rstn, .io_addr, .io_wr, .io_rd, .ds_addr,
        .ds_wr, .ds_rd, .wdata, .rdata, .reg_hit, .conv_busy, .conv_done, .conv_raw,
        .done_flag_clear, .conversion_done_flag, .result_sign_bit, .active_ref_select,
        .ref_internal_on, .ref_avcc_on, .ref_reserved, .diff_mode, .se_channel, .pos_channel,
        .neg_channel, .gain_select, .bandgap_sel, .ground_sel, .chan_reserved);
    adcf_conv_model #(.RAW_W(12)) u_adcf_conv_model (.core_clk, .conv_busy, .conv_done,
        .conv_raw);

    // 40 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
        checks_done++;
        if (got !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, e, got);
        end
    endtask
    // one access, strobe up for one edge
    task automatic acc(input logic [3:0] k, input logic [15:0] a, input logic [7:0] d);
        @(negedge core_clk);
        {ds_rd, ds_wr, io_rd, io_wr} = k;
        io_addr = a[5:0];
        ds_addr = a;
        wdata = d;
        @(negedge core_clk);
        {ds_rd, ds_wr, io_rd, io_wr} = 4'h0;
    endtask
    task automatic rd(input logic [3:0] k, input logic [15:0] a, input logic [7:0] e);
        acc(k, a, 8'h00);
        chk("read data", {8'h00, e}, {8'h00, rdata});
    endtask
    // write select, then let the idle lock copy it
    task automatic sel(input logic [7:0] v);
        acc(IW, 16'h0007, v);
        @(negedge core_clk);
    endtask
    // convert, read both bytes, check sign, clear flag
    task automatic conv(input logic [11:0] raw, input logic [9:0] c, input logic la);
        logic [15:0] e;
        e = la ? {c[9:2], c[1:0], 6'h00} : {6'h00, c[9:8], c[7:0]};
        u_adcf_conv_model.convert(raw, 3);
        chk("done flag", 16'h0001, {15'h0, conversion_done_flag});
        rd(IR, 16'h0004, e[7:0]);
        rd(IR, 16'h0005, e[15:8]);
        chk("sign bit", {15'h0, c[9]}, {15'h0, result_sign_bit});
        done_flag_clear = 1'b1;
        @(negedge core_clk);
        done_flag_clear = 1'b0;
        chk("cleared flag", 16'h0000, {15'h0, conversion_done_flag});
    endtask

    initial begin
        logic [8:0] e;
        {rstn, io_wr, io_rd, ds_wr, ds_rd, done_flag_clear} = 6'h00;
        {io_addr, ds_addr, wdata} = 30'h0;
        repeat (6) @(negedge core_clk);
        rstn = 1'b1;
        rd(IR, 16'h0007, 8'h00);
        acc(IW, 16'h0007, 8'hED);
        rd(DR, 16'h0027, 8'hED);
        acc(DW, 16'h0027, 8'h5A);
        acc(DW, 16'h0067, 8'hFF);
        acc(DW, 16'h0007, 8'hFF);
        rd(IR, 16'h0007, 8'h5A);
        rd(DR, 16'h0067, 8'h00);
        @(negedge core_clk);
        io_addr = 6'h07;
        io_wr = 1'b1;
        wdata = 8'hC3;
        @(negedge core_clk);
        io_wr = 1'b0;
        io_rd = 1'b1;
        @(negedge core_clk);
        io_rd = 1'b0;
        chk("select back", 16'h00C3, {8'h00, rdata});
        $display("test registers done");
        for (int r = 0; r < 4; r++) begin
            sel({r[1:0], 6'h00});
            chk("reference", {14'h0, r[1:0]}, {14'h0, active_ref_select});
            chk("ref decode", {13'h0, r == 3, r == 1, r == 2}, {13'h0, ref_view});
        end
        for (int c = 0; c < 8; c++) begin
            sel({3'h0, c[4:0]});
            chk("single pin", {13'h0, c[2:0]}, {12'h0, diff_mode, se_channel});
        end
        sel(8'h1E);
        chk("bandgap", 16'h0002, {14'h0, bandgap_sel, ground_sel});
        sel(8'h1F);
        chk("ground", 16'h0001, {14'h0, bandgap_sel, ground_sel});
        conv(12'h0C8, 10'h000, 1'b0);
        for (int c = 8; c < 30; c++) begin
            sel({3'h0, c[4:0]});
            if (c < 16)
                e = {2'b10, c[2], c[0], 1'b0, c[2], 1'b0, c[1], ~c[1]};
            else
                e = {1'b1, c[2:0], 1'b0, c[3], ~c[3], 2'b00};
            chk("pair", {7'h0, e}, {7'h0, df_view});
            chk("reserved chan", 16'h0000, {15'h0, chan_reserved});
        end
        $display("test selection done");
        sel(8'hED);
        conv(12'hE70, 10'h270, 1'b1);
        acc(IW, 16'h0007, 8'hCD);
        rd(IR, 16'h0004, 8'h70);
        rd(IR, 16'h0005, 8'h02);
        conv(12'h258, 10'h1FF, 1'b0);
        conv(12'hD44, 10'h200, 1'b0);
        conv(12'h1FF, 10'h1FF, 1'b0);
        conv(12'hE00, 10'h200, 1'b0);
        sel(8'h00);
        conv(12'h5DC, 10'h3FF, 1'b0);
        conv(12'hFFD, 10'h000, 1'b0);
        conv(12'h155, 10'h155, 1'b0);
        sel(8'h20);
        conv(12'h3FF, 10'h3FF, 1'b1);
        conv(12'h2C1, 10'h2C1, 1'b1);
        $display("test coding done");
        sel(8'h40);
        fork
            u_adcf_conv_model.convert(12'h155, 6);
            begin
                repeat (3) @(negedge core_clk);
                acc(IW, 16'h0007, 8'hC5);
                chk("held ref", 16'h0001, {14'h0, active_ref_select});
                chk("held pin", 16'h0000, {12'h0, diff_mode, se_channel});
            end
        join
        chk("new ref", 16'h0003, {14'h0, active_ref_select});
        chk("new pin", 16'h0005, {12'h0, diff_mode, se_channel});
        $display("test lock done");
        stop_test();
    end
endmodule
`default_nettype wire
